// file: state_pointer_pkg.sv
// constants for the pipelined state pointer command decoder
package state_pointer_pkg;
	// ----------------------------------------------------------------
	// command header
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_TYPE = 3'h3;
	localparam logic [1:0] CMD_SUBTYPE = 2'h3;
	localparam logic [2:0] CMD_OPCODE = 3'h0;
	localparam logic [7:0] CMD_SUB_OPCODE = 8'h00;
	localparam logic [7:0] CMD_LENGTH = 8'h05;
	localparam int TYPE_LSB = 29;
	localparam int SUBTYPE_LSB = 27;
	localparam int OPCODE_LSB = 24;
	localparam int SUB_OPCODE_LSB = 16;
	localparam int TOTAL_DWORDS = 7;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int OFS32_LSB = 5;
	localparam int OFS64_LSB = 6;
	localparam int ENABLE_BIT = 0;
	// ----------------------------------------------------------------
	// unit indices and pointer register layout
	// ----------------------------------------------------------------
	localparam int UNIT_VERTEX = 0;
	localparam int UNIT_GEO = 1;
	localparam int UNIT_CLIPPER_STAGE = 2;
	localparam int UNIT_SETUP = 3;
	localparam int UNIT_WINDOWER = 4;
	localparam int UNIT_CC = 5;
	localparam int NUM_UNITS = 6;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD_FIFO = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_BASE = 8'h08;
	localparam logic [7:0] REG_FETCH_ACK = 8'h0C;
	localparam logic [7:0] REG_PTR0 = 8'h10;
	localparam logic [7:0] REG_ENABLES = 8'h28;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : state_pointer_pkg

// file: pointer_slot.sv
// one decoded state pointer with its fetch request flag
`timescale 1ns/1ps
module pointer_slot #(
	parameter int LSB = 5
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [31:0] dword,
	input wire logic active,
	input wire logic [31:0] base,
	input wire logic ack,
	output logic [31:0] address_r,
	output logic fetch_r
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			address_r <= state_pointer_pkg::RESET_WORD;
		end else if (load) begin
			// aligned offset, low bits forced to zero, added to the base
			address_r <= base + {dword[31:LSB], {LSB{1'b0}}};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_r <= 1'b0;
		end else if (load) begin
			fetch_r <= active;
		end else if (ack) begin
			fetch_r <= 1'b0;
		end
	end
endmodule : pointer_slot

// file: state_pointer_decoder.sv
// decoder for the pipelined state pointer command, with AXI4-Lite access
//
// How it works
// [RQ1] dword 2 gives 32-byte geometry state offset
// [RQ2] writer zeros reserved bits; decoder flags violations
// [RQ3] dword 2 bit 0 enables geometry stage
// [RQ4] geometry offset ignored, no fetch when disabled
// [RQ5] writer should enable clipper with geometry stage
// [RQ6] dword 3 gives 32-byte clipper state offset
// [RQ7] dword 3 bit 0 enables clipper stage
// [RQ8] clipper offset ignored while clipper disabled
// [RQ9] dword 4 gives 32-byte setup state offset
// [RQ10] dword 5 gives 32-byte windower state offset
// [RQ11] dword 6 gives 64-byte colour state offset
// [RQ12] accept header type 3/3/0/00, length 5
// [RQ13] units without enable bit always fetch state
// [RQ14] dword 1 gives 32-byte vertex state offset
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module state_pointer_decoder (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic geometry_stage_enable_r,
	output logic clipper_enable_r,
	output logic [5:0] fetch_request_r,
	output logic pointers_valid_r
);
	// ----------------------------------------------------------------
	// decode state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HEADER = 2'b00,
		ST_BODY = 2'b01,
		ST_SKIP = 2'b10
	} decode_state_e;

	decode_state_e state_r;
	logic [2:0] dword_idx_r;
	logic [2:0] skip_left_r;
	logic [31:0] base_r;
	logic bad_header_r;
	logic reserved_error_r;
	logic [7:0] packet_count_r;
	logic [31:0] address_w [state_pointer_pkg::NUM_UNITS];
	logic [5:0] fetch_w;
	logic [5:0] ack_w;
	logic [5:0] load_w;
	logic [5:0] active_w;

	// ----------------------------------------------------------------
	// bus write path
	// ----------------------------------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_go;
	logic wr_hit;
	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			s_axi_awready <= 1'b0;
			waddr_r <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			s_axi_awready <= 1'b0;
			waddr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_bvalid;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_r <= state_pointer_pkg::RESET_WORD;
			wstrb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_r && !s_axi_bvalid;
		end
	end
	assign wr_hit = (waddr_r[7:2] == state_pointer_pkg::REG_CMD_FIFO[7:2])
		|| (waddr_r[7:2] == state_pointer_pkg::REG_BASE[7:2])
		|| (waddr_r[7:2] == state_pointer_pkg::REG_FETCH_ACK[7:2]);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= state_pointer_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? state_pointer_pkg::RESP_OKAY
				: state_pointer_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// command words need all four lanes; partial writes are dropped
	logic cmd_push;
	logic base_wr;
	assign cmd_push = wr_go && (waddr_r[7:2] == state_pointer_pkg::REG_CMD_FIFO[7:2])
		&& (wstrb_r == 4'hF);
	assign base_wr = wr_go && (waddr_r[7:2] == state_pointer_pkg::REG_BASE[7:2]);
	assign ack_w = (wr_go && (waddr_r[7:2] == state_pointer_pkg::REG_FETCH_ACK[7:2]))
		? wdata_r[5:0] : 6'h00;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_r <= state_pointer_pkg::RESET_WORD;
		end else if (base_wr) begin
			for (int b = 0; b < 4; b++) begin
				if (wstrb_r[b]) begin
					base_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
				end
			end
		end
	end
	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic header_ok;
	assign header_ok =
		(wdata_r[31:state_pointer_pkg::TYPE_LSB] == state_pointer_pkg::CMD_TYPE)
		&& (wdata_r[28:state_pointer_pkg::SUBTYPE_LSB] == state_pointer_pkg::CMD_SUBTYPE)
		&& (wdata_r[26:state_pointer_pkg::OPCODE_LSB] == state_pointer_pkg::CMD_OPCODE)
		&& (wdata_r[23:state_pointer_pkg::SUB_OPCODE_LSB]
			== state_pointer_pkg::CMD_SUB_OPCODE)
		&& (wdata_r[7:0] == state_pointer_pkg::CMD_LENGTH); // [RQ12]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_HEADER;
			dword_idx_r <= 3'h0;
			skip_left_r <= 3'h0;
		end else if (cmd_push) begin
			case (state_r)
				ST_HEADER: begin
					dword_idx_r <= 3'h1;
					skip_left_r <= 3'(state_pointer_pkg::TOTAL_DWORDS - 2);
					// unknown header: swallow the same dword count, never decode it
					state_r <= header_ok ? ST_BODY : ST_SKIP; // [RQ12]
				end
				ST_BODY: begin
					dword_idx_r <= dword_idx_r + 3'h1;
					if (dword_idx_r == 3'(state_pointer_pkg::TOTAL_DWORDS - 1)) begin
						state_r <= ST_HEADER;
					end
				end
				ST_SKIP: begin
					skip_left_r <= skip_left_r - 3'h1;
					if (skip_left_r == 3'h0) begin
						state_r <= ST_HEADER;
					end
				end
				default: begin
					state_r <= ST_HEADER;
				end
			endcase
		end
	end
	logic in_body;
	assign in_body = cmd_push && (state_r == ST_BODY);
	always_comb begin
		load_w = 6'h00;
		if (in_body) begin
			load_w = 6'(1) << (dword_idx_r - 3'h1);
		end
	end
	// enable bits sampled from the dword being loaded
	always_comb begin
		active_w = 6'h3F; // [RQ13]
		active_w[state_pointer_pkg::UNIT_GEO] = wdata_r[state_pointer_pkg::ENABLE_BIT]; // [RQ4]
		// clipper offset is ignored while its enable is clear
		active_w[state_pointer_pkg::UNIT_CLIPPER_STAGE] = wdata_r[state_pointer_pkg::ENABLE_BIT]; // [RQ8]
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			geometry_stage_enable_r <= 1'b0;
			clipper_enable_r <= 1'b0;
		end else begin
			if (load_w[state_pointer_pkg::UNIT_GEO]) begin
				geometry_stage_enable_r <= wdata_r[state_pointer_pkg::ENABLE_BIT]; // [RQ3]
			end
			if (load_w[state_pointer_pkg::UNIT_CLIPPER_STAGE]) begin
				clipper_enable_r <= wdata_r[state_pointer_pkg::ENABLE_BIT]; // [RQ7]
			end
		end
	end
	// reserved fields: device only reports, the writer must keep them zero
	logic reserved_bad;
	always_comb begin
		reserved_bad = 1'b0;
		if (in_body) begin
			case (dword_idx_r)
				3'h1: reserved_bad = |wdata_r[4:0];
				3'h2: reserved_bad = |wdata_r[4:1]; // [RQ2]
				3'h3: reserved_bad = |wdata_r[4:1]; // [RQ2]
				3'h4: reserved_bad = |wdata_r[4:0];
				3'h5: reserved_bad = |wdata_r[4:0]; // [RQ2]
				3'h6: reserved_bad = |wdata_r[5:0]; // [RQ2]
				default: reserved_bad = 1'b0;
			endcase
		end
	end
	// sticky flags are cleared by a write of 1 to fetch ack bit 7/6, the reserved flag also by any of bits 5:0; set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reserved_error_r <= 1'b0;
			bad_header_r <= 1'b0;
		end else begin
			if (reserved_bad) begin
				reserved_error_r <= 1'b1;
			end else if (ack_w != 6'h00 || (wr_go && wdata_r[6]
				&& waddr_r[7:2] == state_pointer_pkg::REG_FETCH_ACK[7:2])) begin
				reserved_error_r <= 1'b0;
			end
			if (cmd_push && state_r == ST_HEADER && !header_ok) begin
				bad_header_r <= 1'b1;
			end else if (wr_go && wdata_r[7]
				&& waddr_r[7:2] == state_pointer_pkg::REG_FETCH_ACK[7:2]) begin
				bad_header_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pointers_valid_r <= 1'b0;
			packet_count_r <= 8'h00;
		end else if (in_body && dword_idx_r == 3'(state_pointer_pkg::TOTAL_DWORDS - 1)) begin
			pointers_valid_r <= 1'b1;
			packet_count_r <= packet_count_r + 8'h01;
		end
	end
	// ----------------------------------------------------------------
	// pointer slots: vertex, geometry, clipper, setup, windower, colour
	// ----------------------------------------------------------------
	genvar u;
	generate
		for (u = 0; u < state_pointer_pkg::NUM_UNITS; u++) begin : g_slot
			localparam int LSB = (u == state_pointer_pkg::UNIT_CC)
				? state_pointer_pkg::OFS64_LSB : state_pointer_pkg::OFS32_LSB;
			pointer_slot #(
				.LSB(LSB) // [RQ1] [RQ6] [RQ9] [RQ10] [RQ11] [RQ14]
			) u_slot (
				.aclk(aclk),
				.aresetn(aresetn),
				.load(load_w[u]),
				.dword(wdata_r),
				.active(active_w[u]),
				.base(base_r),
				.ack(ack_w[u]),
				.address_r(address_w[u]),
				.fetch_r(fetch_w[u])
			);
		end
	endgenerate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_request_r <= 6'h00;
		end else begin
			fetch_request_r <= fetch_w & ~ack_w;
		end
	end
	// ----------------------------------------------------------------
	// bus read path
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic rd_hit;
	logic [5:0] rd_slot;
	assign rd_slot = 6'(s_axi_araddr[7:2] - state_pointer_pkg::REG_PTR0[7:2]);
	always_comb begin
		rd_word = state_pointer_pkg::RESET_WORD;
		rd_hit = 1'b1;
		case (s_axi_araddr[7:2])
			state_pointer_pkg::REG_STATUS[7:2]: rd_word = {packet_count_r, 16'h0000,
				1'b0, bad_header_r, reserved_error_r, pointers_valid_r,
				2'(state_r), 2'b00};
			state_pointer_pkg::REG_BASE[7:2]: rd_word = base_r;
			state_pointer_pkg::REG_FETCH_ACK[7:2]: rd_word = {26'h0, fetch_w};
			state_pointer_pkg::REG_ENABLES[7:2]: rd_word = {30'h0, clipper_enable_r,
				geometry_stage_enable_r};
			default: begin
				if (rd_slot < 6'(state_pointer_pkg::NUM_UNITS)) begin
					rd_word = address_w[rd_slot[2:0]];
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= state_pointer_pkg::RESET_WORD;
			s_axi_rresp <= state_pointer_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? state_pointer_pkg::RESP_OKAY
				: state_pointer_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule : state_pointer_decoder

// file: pipeline_stage_model.sv
// fixed-function stage model that records each pending fetch request
`timescale 1ns/1ps
module pipeline_stage_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] fetch_request,
	output logic [5:0] fetched_r
);
	// stages only remember which units were ever asked to fetch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetched_r <= 6'h00;
		end else begin
			fetched_r <= fetched_r | fetch_request;
		end
	end
endmodule : pipeline_stage_model

// file: state_pointer_decoder_asserts.sv
// concurrent checks on the state pointer decoder ports
`timescale 1ns/1ps
module state_pointer_decoder_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic geometry_stage_enable_r,
	input wire logic clipper_enable_r,
	input wire logic [5:0] fetch_request_r,
	input wire logic pointers_valid_r
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_geo_fetch: assert property ($rose(fetch_request_r[1]) |-> geometry_stage_enable_r)
		else $error("geometry fetch while disabled");
	a_clipper_stage_fetch: assert property ($rose(fetch_request_r[2]) |-> clipper_enable_r)
		else $error("clipper fetch while disabled");
	a_colour_valid: assert property ($rose(fetch_request_r[5]) |-> ##[0:2] pointers_valid_r)
		else $error("colour fetch without valid pointers");
endmodule : state_pointer_decoder_asserts
bind state_pointer_decoder state_pointer_decoder_asserts state_pointer_decoder_asserts_i (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .geometry_stage_enable_r(geometry_stage_enable_r),
	.clipper_enable_r(clipper_enable_r), .fetch_request_r(fetch_request_r),
	.pointers_valid_r(pointers_valid_r)
);

// file: state_pointer_decoder_tb_top.sv
// register-level testbench for the state pointer decoder
`timescale 1ns/1ps
module state_pointer_decoder_tb_top;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic awready, wready, arready, geo, clipper_stage, pv;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, base, pkt [0:6], exp_addr [0:5];
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [5:0] fetch, fetched;
	int err_total, compares;
	state_pointer_decoder state_pointer_decoder_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.geometry_stage_enable_r(geo), .clipper_enable_r(clipper_stage), .fetch_request_r(fetch),
		.pointers_valid_r(pv));
	pipeline_stage_model pipeline_stage_model_i (.aclk(aclk), .aresetn(aresetn),
		.fetch_request(fetch), .fetched_r(fetched));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task close_out;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		// idle edge: a strobe is never dropped and raised in one step
		@(posedge aclk);
		if (n == 200) begin err_total++; close_out(); end
	endtask : wr
	task rd(input logic [7:0] a);
		int n;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata; r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
		if (n == 200) begin err_total++; close_out(); end
	endtask : rd
	task send_pkt;
		for (int i = 0; i < state_pointer_pkg::TOTAL_DWORDS; i++) wr(state_pointer_pkg::REG_CMD_FIFO, pkt[i]);
		repeat (2) @(posedge aclk);
	endtask : send_pkt
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		logic g, c;
		err_total = 0; compares = 0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
		base = 32'h0001_0000;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({pv, fetch}, 32'h0);
		rd(8'h30); chk(r, state_pointer_pkg::RESP_SLVERR);
		wr(8'h30, 32'h1); chk(r, state_pointer_pkg::RESP_SLVERR);
		wr(state_pointer_pkg::REG_BASE, base);
		rd(state_pointer_pkg::REG_BASE); chk(d, base);
		pkt[0] = {state_pointer_pkg::CMD_TYPE, state_pointer_pkg::CMD_SUBTYPE,
			state_pointer_pkg::CMD_OPCODE, 8'h01, 8'h00, state_pointer_pkg::CMD_LENGTH};
		for (int i = 1; i < 7; i++) pkt[i] = 32'h0000_0120 * i;
		send_pkt();
		rd(state_pointer_pkg::REG_STATUS); chk(d[6], 1'b1);
		chk({pv, fetch}, 32'h0);
		wr(state_pointer_pkg::REG_FETCH_ACK, 32'h80);
		pkt[0][23:16] = state_pointer_pkg::CMD_SUB_OPCODE;
		for (int k = 0; k < 4; k++) begin
			g = k[0]; c = k[1] | k[0];
			pkt[2] = 32'h0000_0240 | 32'(g);
			pkt[3] = 32'h0000_0360 | 32'(c);
			for (int u = 0; u < 5; u++) exp_addr[u] = base + (pkt[u + 1] & 32'hFFFF_FFE0);
			exp_addr[5] = base + (pkt[6] & 32'hFFFF_FFC0);
			send_pkt();
			chk(fetch, {4'hF, c, g, 1'b1} & 6'h3F);
			chk({geo, clipper_stage, pv}, {g, c, 1'b1});
			for (int u = 0; u < 6; u++) begin
				if ((u == 1 && !g) || (u == 2 && !c)) continue;
				rd(state_pointer_pkg::REG_PTR0 + 8'(4 * u));
				chk(d, exp_addr[u]);
			end
			rd(state_pointer_pkg::REG_ENABLES); chk(d[1:0], {c, g});
			wr(state_pointer_pkg::REG_FETCH_ACK, 32'h3F);
			repeat (2) @(posedge aclk);
			chk(fetch, 6'h00);
		end
		chk(fetched, 6'h3F);
		close_out();
	end
endmodule : state_pointer_decoder_tb_top
